// >>> rtl/jfp_host.sv
// Host controller driving the flash programming port over TAP pins
// Overview of operation
// - signature read: enter, load address, two read words; byte in low bits
// - calibration read: enter, load address, two read words; byte in low bits
// - no-operation is two words and cancels any entered operation
// - a word only setting the upper seven bits may be skipped if unchanged
// - poll word is repeated until the poll bit reads 1; the code stops after 4096 words and sets rsp_timeout
// - fuse write data 0 programs, 1 unprograms
// - lock write data 0 programs, 1 leaves the bit unchanged
// - page load updates are at least 11 TCK cycles apart
// - enter: reset register 1, then 16-bit key into enable register
// - leave: no-operation, zero key, then reset register 0
// - chip erase must precede flash programming
// - word writes follow enable, address, data, latch, page write, poll
`include "jfp_cfg.svh"

module jfp_host import jfp_pkg::*; (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire jfp_op_t     cmd_op,
  input  wire logic [14:0] cmd_word,
  input  wire logic        cmd_skip,
  output logic             cmd_ready,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data,
  output logic             rsp_err,
  output logic             rsp_timeout,
  output logic             tck,
  output logic             tms,
  output logic             tdi,
  input  wire logic        tdo
);

  jfp_state_t  state_q;
  jfp_op_t     op_q;
  logic [14:0] word_q;
  logic [3:0]  step_n_q;
  logic [3:0]  cur_ir_q;
  logic        ir_known_q;
  logic [6:0]  last_hi_q;
  logic        erased_q;
  logic        boot_q;
  logic        err_q;
  logic        tmo_q;
  logic [11:0] poll_cnt_q;
  logic [3:0]  cnt_q;
  logic [4:0]  idx_q;
  logic [4:0]  tot_q;
  logic [4:0]  pre_q;
  logic [4:0]  len_q;
  logic [15:0] data_q;
  logic        is_ir_q;
  logic [23:0] tms_vec_q;
  logic [23:0] tdi_vec_q;
  logic [15:0] cap_q;
  logic [4:0]  gap_q;
  logic        tdo_s1_q;
  logic        tdo_s2_q;
  logic        tick;
  logic        rise;
  logic        fall;
  logic        last;
  logic        upd_rise;
  logic        skip_hit;
  logic        refuse;
  jfp_step_t   st;
  logic [4:0]  pre_b;
  logic [4:0]  tot_b;
  logic [23:0] tms_b;
  logic [23:0] tdi_b;

  // Micro-steps of each operation; instruction steps are skipped if loaded
  function automatic jfp_step_t step_of(input jfp_op_t    op,
                                        input logic [3:0]  n,
                                        input logic [14:0] w);
    jfp_step_t s;
    s = '{1'b1, 1'b1, 16'h0000, `JFP_IR_LEN};
    unique case (op)
      JFP_OP_ENTER: begin
        case (n)
          4'h0: s.val = {12'h000, `JFP_IR_RESET};
          4'h1: s = '{1'b1, 1'b0, 16'h0001, 5'h01};
          4'h2: s.val = {12'h000, `JFP_IR_KEY};
          4'h3: s = '{1'b1, 1'b0, `JFP_PROG_KEY, 5'h10};
          default: s.valid = 1'b0;
        endcase
      end
      JFP_OP_LEAVE: begin
        case (n)
          4'h0: s.val = {12'h000, `JFP_IR_CMD};
          4'h1: s = '{1'b1, 1'b0, {1'b0, `JFP_NOP_A}, 5'h0f};
          4'h2: s = '{1'b1, 1'b0, {1'b0, `JFP_NOP_B}, 5'h0f};
          4'h3: s.val = {12'h000, `JFP_IR_KEY};
          4'h4: s = '{1'b1, 1'b0, `JFP_PROG_CLEAR, 5'h10};
          4'h5: s.val = {12'h000, `JFP_IR_RESET};
          4'h6: s = '{1'b1, 1'b0, 16'h0000, 5'h01};
          default: s.valid = 1'b0;
        endcase
      end
      JFP_OP_CMD, JFP_OP_POLL: begin
        // Word passed as given, fuse and lock data bits untouched
        case (n)
          4'h0: s.val = {12'h000, `JFP_IR_CMD};
          4'h1: s = '{1'b1, 1'b0, {1'b0, w}, 5'h0f};
          default: s.valid = 1'b0;
        endcase
      end
      JFP_OP_LOAD, JFP_OP_READ: begin
        case (n)
          4'h0: s.val = {12'h000, (op == JFP_OP_LOAD) ? `JFP_IR_PLOAD
                                                      : `JFP_IR_PREAD};
          4'h1: s = '{1'b1, 1'b0, {8'h00, w[7:0]}, 5'h08};
          default: s.valid = 1'b0;
        endcase
      end
    endcase
    return s;
  endfunction

  // TMS walk: IR 1,1,0,0 or DR 1,0,0, bits, then exit and update, to idle
  always_comb begin
    st = step_of(op_q, step_n_q, word_q);
    pre_b = st.ir ? 5'h04 : 5'h03;
    tms_b = 24'h00_0000;
    tdi_b = 24'h00_0000;
    tms_b[0] = 1'b1;
    tms_b[1] = st.ir;
    for (int i = 0; i < 16; i++) begin
      if (i < int'(st.len)) begin
        tdi_b[i + int'(pre_b)] = st.val[i];
      end
    end
    tms_b[int'(pre_b) + int'(st.len) - 1] = 1'b1;
    tms_b[int'(pre_b) + int'(st.len)] = 1'b1;
    tot_b = 5'(pre_b + st.len + 5'h02);
  end

  assign tick     = (state_q == JFP_ST_RUN || state_q == JFP_ST_GAP) &&
                    (cnt_q == `JFP_TCK_HALF - 4'h1);
  assign rise     = tick && !tck;
  assign fall     = tick && tck;
  assign last     = idx_q == tot_q - 5'h01;
  assign upd_rise = rise && state_q == JFP_ST_RUN && op_q == JFP_OP_LOAD &&
                    !is_ir_q && idx_q == pre_q + len_q;
  assign skip_hit = cmd_op == JFP_OP_CMD && cmd_skip && ir_known_q &&
                    cur_ir_q == `JFP_IR_CMD && cmd_word[14:8] == last_hi_q;
  assign refuse   = (cmd_op == JFP_OP_LOAD && !(ir_known_q &&
                    (cur_ir_q == `JFP_IR_CMD || cur_ir_q == `JFP_IR_PLOAD))) ||
                    ((cmd_op == JFP_OP_LOAD || (cmd_op == JFP_OP_CMD &&
                    cmd_word[14:8] == `JFP_PAGE_WRITE_HI)) && !erased_q);

  // Device output crosses into this clock before use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tdo_s1_q <= 1'b0;
      tdo_s2_q <= 1'b0;
    end else begin
      tdo_s1_q <= tdo;
      tdo_s2_q <= tdo_s1_q;
    end
  end

  // TCK divider; clock runs in the shift and gap states and stands low in all others
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 4'h0;
      tck   <= 1'b0;
    end else if (state_q != JFP_ST_RUN && state_q != JFP_ST_GAP) begin
      cnt_q <= 4'h0;
      tck   <= 1'b0;
    end else if (tick) begin
      cnt_q <= 4'h0;
      tck   <= !tck;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  // TDO is sampled at the rising edge while the device is shifting a data register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cap_q <= 16'h0000;
    end else if (state_q == JFP_ST_PLAN && st.valid) begin
      // Kept through the closing plan step so the answer still carries it
      cap_q <= 16'h0000;
    end else if (rise && state_q == JFP_ST_RUN && !is_ir_q &&
                 idx_q >= pre_q && idx_q < pre_q + len_q) begin
      cap_q[4'(idx_q - pre_q)] <= tdo_s2_q;
    end
  end

  // TCK cycles since the last page load update, saturating
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_q <= 5'h1f;
    end else if (upd_rise) begin
      gap_q <= 5'h00;
    end else if (rise && gap_q != 5'h1f) begin
      gap_q <= gap_q + 5'h01;
    end
  end

  // Sequencer; after reset it walks the TAP to Run-Test/Idle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q    <= JFP_ST_RUN;
      boot_q     <= 1'b1;
      tms_vec_q  <= 24'h00_001f;
      tdi_vec_q  <= 24'h00_0000;
      tot_q      <= 5'h06;
      pre_q      <= 5'h00;
      len_q      <= 5'h00;
      data_q     <= 16'h0000;
      is_ir_q    <= 1'b0;
      idx_q      <= 5'h00;
      tms        <= 1'b1;
      tdi        <= 1'b0;
      op_q       <= JFP_OP_CMD;
      word_q     <= 15'h0000;
      step_n_q   <= 4'h0;
      cur_ir_q   <= 4'h0;
      ir_known_q <= 1'b0;
      last_hi_q  <= 7'h00;
      erased_q   <= 1'b0;
      err_q      <= 1'b0;
      tmo_q      <= 1'b0;
      poll_cnt_q <= 12'h000;
      cmd_ready  <= 1'b0;
      rsp_valid  <= 1'b0;
      rsp_data   <= 16'h0000;
      rsp_err    <= 1'b0;
      rsp_timeout <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      unique case (state_q)
        JFP_ST_IDLE: begin
          if (cmd_valid && cmd_ready) begin
            cmd_ready  <= 1'b0;
            op_q       <= cmd_op;
            word_q     <= cmd_word;
            step_n_q   <= 4'h0;
            poll_cnt_q <= 12'h000;
            err_q      <= 1'b0;
            tmo_q      <= 1'b0;
            if (skip_hit) begin
              state_q <= JFP_ST_DONE;
            end else if (refuse) begin
              err_q   <= 1'b1;
              state_q <= JFP_ST_DONE;
            end else begin
              if (cmd_op == JFP_OP_ENTER) begin
                erased_q <= 1'b0;
              end
              state_q <= JFP_ST_PLAN;
            end
          end
        end
        JFP_ST_PLAN: begin
          if (!st.valid) begin
            state_q <= JFP_ST_DONE;
          end else if (st.ir && ir_known_q && cur_ir_q == st.val[3:0]) begin
            step_n_q <= step_n_q + 4'h1;
          end else begin
            tms_vec_q <= tms_b;
            tdi_vec_q <= tdi_b;
            tot_q     <= tot_b;
            pre_q     <= pre_b;
            len_q     <= st.len;
            data_q    <= st.val;
            is_ir_q   <= st.ir;
            idx_q     <= 5'h00;
            // Short shifts would crowd two updates; idle first
            if (op_q == JFP_OP_LOAD && !st.ir &&
                {1'b0, gap_q} + {1'b0, tot_b} - 6'h01 < `JFP_PL_GAP) begin
              tms     <= 1'b0;
              state_q <= JFP_ST_GAP;
            end else begin
              tms     <= tms_b[0];
              tdi     <= tdi_b[0];
              state_q <= JFP_ST_RUN;
            end
          end
        end
        JFP_ST_GAP: begin
          if (fall &&
              {1'b0, gap_q} + {1'b0, tot_q} - 6'h01 >= `JFP_PL_GAP) begin
            tms     <= tms_vec_q[0];
            tdi     <= tdi_vec_q[0];
            state_q <= JFP_ST_RUN;
          end
        end
        JFP_ST_RUN: begin
          if (fall && !last) begin
            idx_q <= idx_q + 5'h01;
            tms   <= tms_vec_q[idx_q + 5'h01];
            tdi   <= tdi_vec_q[idx_q + 5'h01];
          end else if (fall) begin
            tms <= 1'b0;
            tdi <= 1'b0;
            if (boot_q) begin
              boot_q    <= 1'b0;
              cmd_ready <= 1'b1;
              state_q   <= JFP_ST_IDLE;
            end else if (is_ir_q) begin
              cur_ir_q   <= data_q[3:0];
              ir_known_q <= 1'b1;
              step_n_q   <= step_n_q + 4'h1;
              state_q    <= JFP_ST_PLAN;
            end else if (op_q == JFP_OP_POLL && !cap_q[`JFP_POLL_BIT] &&
                         poll_cnt_q != `JFP_POLL_MAX) begin
              poll_cnt_q <= poll_cnt_q + 12'h001;
              state_q    <= JFP_ST_PLAN;
            end else begin
              tmo_q    <= op_q == JFP_OP_POLL && !cap_q[`JFP_POLL_BIT];
              step_n_q <= step_n_q + 4'h1;
              state_q  <= JFP_ST_PLAN;
              if (len_q == 5'h0f) begin
                last_hi_q <= data_q[14:8];
                if (data_q[14:0] == `JFP_CHIP_ERASE) begin
                  erased_q <= 1'b1;
                end
              end
            end
          end
        end
        JFP_ST_DONE: begin
          rsp_valid   <= 1'b1;
          rsp_data    <= cap_q;
          rsp_err     <= err_q;
          rsp_timeout <= tmo_q;
          cmd_ready   <= 1'b1;
          state_q     <= JFP_ST_IDLE;
        end
      endcase
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_TCK_HALF: assert property (
    $rose(tck) |-> tck [*8] ##1 !tck)
    else $error("TCK high phase has wrong length");
  AST_TMS_LOW_TCK: assert property (
    $changed(tms) |-> !tck)
    else $error("TMS changed while TCK high");
  AST_CMD_LEN: assert property (
    (state_q == JFP_ST_RUN && !is_ir_q && !boot_q &&
     (op_q == JFP_OP_CMD || op_q == JFP_OP_POLL)) |-> len_q == 5'h0f)
    else $error("Command word not 15 bits");
  AST_POLL_BIT: assert property (
    (rsp_valid && op_q == JFP_OP_POLL && !rsp_timeout && !rsp_err)
      |-> rsp_data[`JFP_POLL_BIT])
    else $error("Poll finished without completion bit");
  AST_SKIP: assert property (
    (state_q == JFP_ST_IDLE && cmd_valid && cmd_ready && skip_hit)
      |=> (!tck && state_q == JFP_ST_DONE) ##1 (rsp_valid && !rsp_err))
    else $error("Redundant command word was shifted");
  AST_ERASE_FIRST: assert property (
    (state_q == JFP_ST_RUN && op_q == JFP_OP_LOAD) |-> erased_q)
    else $error("Page load without chip erase");
  AST_PL_GAP: assert property (
    upd_rise |-> {1'b0, gap_q} + 6'h01 >= `JFP_PL_GAP)
    else $error("Page load updates too close");
  AST_ENTER_KEY: assert property (
    (state_q == JFP_ST_RUN && op_q == JFP_OP_ENTER && len_q == 5'h10)
      |-> data_q == `JFP_PROG_KEY)
    else $error("Wrong programming key");
  AST_LEAVE_ZERO: assert property (
    (state_q == JFP_ST_RUN && op_q == JFP_OP_LEAVE && len_q == 5'h10)
      |-> data_q == `JFP_PROG_CLEAR)
    else $error("Leave did not clear key");
  AST_NOP_PAIR: assert property (
    (state_q == JFP_ST_RUN && op_q == JFP_OP_LEAVE && step_n_q == 4'h1)
      |-> data_q[14:0] == `JFP_NOP_A)
    else $error("No-operation first word wrong");

endmodule

// >>> rtl/jfp_cfg.svh
// Constants for the flash programming port host controller
`ifndef JFP_CFG_SVH
`define JFP_CFG_SVH
// Core cycles per half TCK period
`define JFP_TCK_HALF       4'h8
// Instruction register length and instruction codes (arbitrary values)
`define JFP_IR_LEN         5'h04
`define JFP_IR_RESET       4'hc
`define JFP_IR_KEY         4'h4
`define JFP_IR_CMD         4'h5
`define JFP_IR_PLOAD       4'h6
`define JFP_IR_PREAD       4'h7
// Programming mode key and its clearing value
`define JFP_PROG_KEY       16'ha370
`define JFP_PROG_CLEAR     16'h0000
// No operation command words
`define JFP_NOP_A          15'h2300
`define JFP_NOP_B          15'h3300
// Upper seven command bits of the page write word
`define JFP_PAGE_WRITE_HI  7'h35
// Chip erase start word (plain default)
`define JFP_CHIP_ERASE     15'h2380
// Completion poll bit position and poll limit
`define JFP_POLL_BIT       9
`define JFP_POLL_MAX       12'hfff
// Least TCK cycles between two page load updates
`define JFP_PL_GAP         6'h0b
`endif

// >>> rtl/jfp_pkg.sv
// Types for the flash programming port host controller
package jfp_pkg;
  typedef enum logic [2:0] {
    JFP_OP_ENTER,
    JFP_OP_LEAVE,
    JFP_OP_CMD,
    JFP_OP_POLL,
    JFP_OP_LOAD,
    JFP_OP_READ
  } jfp_op_t;

  typedef enum logic [2:0] {
    JFP_ST_IDLE,
    JFP_ST_PLAN,
    JFP_ST_GAP,
    JFP_ST_RUN,
    JFP_ST_DONE
  } jfp_state_t;

  typedef struct packed {
    logic        valid;
    logic        ir;
    logic [15:0] val;
    logic [4:0]  len;
  } jfp_step_t;
endpackage

// >>> tb/jfp_dev_model.sv
// Behavioural device behind the TAP pins of the programming port
`include "jfp_cfg.svh"
module jfp_dev_model #(
  parameter logic [23:0] SIG   = 24'h12_3456, // Arbitrary signature bytes
  parameter logic [7:0]  CAL   = 8'h3c,
  parameter logic [31:0] FUSES = 32'hfdd9_62fc, // Ext, high, low, lock
  parameter int          BUSY  = 3
) (
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo
);
  logic [3:0]  st, ir, ir_sr;
  logic [15:0] sr, out_q, key;
  logic [7:0]  mode;
  logic [1:0]  sig_a;
  logic [5:0]  addr;
  logic [15:0] mem [64];
  logic        rst_reg, prog_en, hi_ld, hi_rd, pl_first, gap_err;
  int          busy, polls, updates, since;

  function automatic logic [3:0] nxt(logic [3:0] s, logic m);
    case (s)
      4'h0:             return m ? 4'h0 : 4'h1;
      4'h1, 4'h8, 4'hf: return m ? 4'h2 : 4'h1;
      4'h2:             return m ? 4'h9 : 4'h3;
      4'h3, 4'h4:       return m ? 4'h5 : 4'h4;
      4'h5:             return m ? 4'h8 : 4'h6;
      4'h6:             return m ? 4'h7 : 4'h6;
      4'h7:             return m ? 4'h8 : 4'h4;
      4'h9:             return m ? 4'h0 : 4'ha;
      4'ha, 4'hb:       return m ? 4'hc : 4'hb;
      4'hc:             return m ? 4'hf : 4'hd;
      4'hd:             return m ? 4'he : 4'hd;
      default:          return m ? 4'hf : 4'hb;
    endcase
  endfunction

  function automatic int dr_len(logic [3:0] i);
    case (i)
      `JFP_IR_KEY:                  return 16;
      `JFP_IR_CMD:                  return 15;
      `JFP_IR_PLOAD, `JFP_IR_PREAD: return 8;
      default:                      return 1;
    endcase
  endfunction

  task automatic do_cmd(logic [14:0] w);
    updates++;
    out_q = 16'h0000;
    case (w[14:8])
      7'h23: mode = w[7:0];
      7'h03: begin // Bits above the implemented address are dropped
        sig_a = w[1:0];
        addr = w[5:0];
      end
      7'h32: out_q[7:0] = (mode == 8'h08) ? SIG[8*int'(sig_a) +: 8]
                                          : FUSES[15:8];
      7'h36: out_q[7:0] = CAL;
      7'h3a: out_q[7:0] = FUSES[31:24];
      7'h3e: out_q[7:0] = FUSES[23:16];
      7'h33: out_q[7:0] = (mode == 8'h04) ? FUSES[7:0] : 8'h00;
      7'h37: begin
        polls++;
        out_q[9] = (busy == 0);
        if (busy > 0) busy--;
      end
      default: ;
    endcase
    if (w == `JFP_CHIP_ERASE) begin
      busy = BUSY;
      polls = 0;
    end
  endtask

  task automatic update();
    case (ir)
      `JFP_IR_RESET: rst_reg = sr[0];
      `JFP_IR_KEY: begin
        key = sr;
        prog_en = rst_reg && sr == `JFP_PROG_KEY;
      end
      `JFP_IR_CMD: if (prog_en) do_cmd(sr[14:0]);
      `JFP_IR_PLOAD: if (prog_en) begin
        if (since < `JFP_PL_GAP) gap_err = 1'b1;
        since = 0;
        if (hi_ld) mem[addr][15:8] = sr[7:0];
        else begin
          if (!pl_first) addr++;
          mem[addr][7:0] = sr[7:0];
          pl_first = 1'b0;
        end
        hi_ld = ~hi_ld;
      end
      default: ;
    endcase
  endtask

  initial begin
    {st, ir_sr, sr, out_q, key, mode, sig_a, addr} = '0;
    ir = 4'h1;
    {tdo, rst_reg, prog_en, hi_ld, hi_rd, gap_err} = '0;
    pl_first = 1'b1;
    {busy, polls, updates} = '0;
    since = 100;
    foreach (mem[i]) mem[i] = 16'hffff;
  end

  always @(posedge tck) begin
    since++;
    case (st)
      4'h3: if (ir == `JFP_IR_PREAD) begin
        sr = {8'h00, hi_rd ? mem[addr][15:8] : mem[addr][7:0]};
        if (hi_rd) addr++;
        hi_rd = ~hi_rd;
      end else sr = (ir == `JFP_IR_CMD) ? out_q : 16'h0000;
      4'h4: sr = (sr >> 1) | (16'(tdi) << (dr_len(ir) - 1));
      4'h8: update();
      4'ha: ir_sr = 4'h1;
      4'hb: ir_sr = {tdi, ir_sr[3:1]};
      4'hf: begin // New instruction restarts byte alternation
        ir = ir_sr;
        hi_rd = 1'b0;
        hi_ld = 1'b0;
        pl_first = 1'b1;
      end
      default: ;
    endcase
    st = nxt(st, tms);
  end

  // Outside shifts the line toggles so a stale bit never looks valid
  always @(negedge tck)
    tdo = (st == 4'h4) ? sr[0] : (st == 4'hb) ? ir_sr[0] : ~tdo;
endmodule

// >>> tb/jfp_host_tb_top.sv
// Self-checking bench for the programming port host controller
`include "jfp_cfg.svh"
`define CHK(got, exp) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module jfp_host_tb_top import jfp_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [23:0] SIG   = 24'h12_3456; // Arbitrary signature bytes
  localparam logic [7:0]  CAL   = 8'h3c;
  localparam logic [31:0] FUSES = 32'hfdd9_62fc;
  localparam int          BUSY  = 3;
  logic        core_clk, rst, cmd_valid, cmd_skip;
  jfp_op_t     cmd_op;
  logic [14:0] cmd_word;
  logic        cmd_ready, rsp_valid, rsp_err, rsp_timeout;
  logic        tck, tms, tdi, tdo;
  logic [15:0] rsp_data;
  logic [14:0] fw [4] = '{15'h3e00, 15'h3200, 15'h3300, 15'h3300};
  int          num_errors, n_tests, cycles;

  jfp_host u_dut (.core_clk(core_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_op(cmd_op), .cmd_word(cmd_word), .cmd_skip(cmd_skip),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_err(rsp_err), .rsp_timeout(rsp_timeout), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo));
  jfp_dev_model #(.SIG(SIG), .CAL(CAL), .FUSES(FUSES), .BUSY(BUSY)) u_dev (
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  // Longest path is under two thousand cycles per request
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic issue(jfp_op_t op, logic [14:0] w, logic skip = 1'b0);
    int n;
    n = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 400) begin
      @(negedge core_clk);
      n++;
    end
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_word = w;
    cmd_skip = skip;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
    `CHK(rsp_valid, 1'b1)
  endtask

  task automatic t_enter();
    issue(JFP_OP_ENTER, 15'h0000);
    `CHK(rsp_err, 1'b0)
    `CHK(u_dev.rst_reg, 1'b1)
    `CHK(u_dev.prog_en, 1'b1)
    $display("enter done");
  endtask

  task automatic t_refuse();
    issue(JFP_OP_LOAD, 15'h0011);
    `CHK(rsp_err, 1'b1)
    issue(JFP_OP_CMD, 15'h3500);
    `CHK(rsp_err, 1'b1)
    `CHK(u_dev.updates, 0)
    $display("refuse done");
  endtask

  task automatic t_sig_cal();
    issue(JFP_OP_CMD, 15'h2308);
    issue(JFP_OP_CMD, 15'h0302);
    issue(JFP_OP_CMD, 15'h3200);
    issue(JFP_OP_CMD, 15'h3300);
    `CHK(rsp_data[7:0], SIG[23:16])
    issue(JFP_OP_CMD, 15'h3300, 1'b1);
    `CHK(rsp_err, 1'b0)
    `CHK(u_dev.updates, 4)
    issue(JFP_OP_CMD, 15'h0300);
    issue(JFP_OP_CMD, 15'h3600);
    issue(JFP_OP_CMD, 15'h3700);
    `CHK(rsp_data[7:0], CAL)
    $display("signature and calibration done");
  endtask

  task automatic t_fuse();
    issue(JFP_OP_CMD, 15'h2304);
    issue(JFP_OP_CMD, 15'h3a00);
    for (int i = 0; i < 4; i++) begin
      issue(JFP_OP_CMD, fw[i]);
      `CHK(rsp_data[7:0], FUSES[31-8*i -: 8])
    end
    // Write data bits must reach the device exactly as given
    issue(JFP_OP_CMD, 15'h13a5);
    `CHK(u_dev.sr[14:0], 15'h13a5)
    $display("fuse read done");
  endtask

  task automatic t_erase();
    issue(JFP_OP_CMD, `JFP_CHIP_ERASE);
    issue(JFP_OP_POLL, 15'h3700);
    `CHK(rsp_data[9], 1'b1)
    `CHK(rsp_timeout, 1'b0)
    `CHK(u_dev.polls, BUSY + 2)
    $display("erase done");
  endtask

  task automatic t_load();
    issue(JFP_OP_CMD, 15'h2310);
    issue(JFP_OP_CMD, 15'h0340);
    for (int i = 1; i <= 4; i++) issue(JFP_OP_LOAD, 15'(8'h11 * i));
    `CHK(u_dev.mem[0], 16'h2211)
    `CHK(u_dev.mem[1], 16'h4433)
    `CHK(u_dev.addr, 6'h01)
    `CHK(u_dev.gap_err, 1'b0)
    issue(JFP_OP_CMD, 15'h3500);
    `CHK(rsp_err, 1'b0)
    $display("page load done");
  endtask

  task automatic t_read();
    issue(JFP_OP_CMD, 15'h2302);
    issue(JFP_OP_CMD, 15'h0300);
    for (int i = 1; i <= 4; i++) begin
      issue(JFP_OP_READ, 15'h0000);
      `CHK(rsp_data[7:0], 8'(8'h11 * i))
    end
    `CHK(u_dev.addr, 6'h02)
    issue(JFP_OP_LOAD, 15'h0055);
    `CHK(rsp_err, 1'b1)
    $display("page read done");
  endtask

  task automatic t_leave();
    issue(JFP_OP_LEAVE, 15'h0000);
    `CHK(u_dev.mode, 8'h00)
    `CHK(u_dev.key, `JFP_PROG_CLEAR)
    `CHK(u_dev.rst_reg, 1'b0)
    `CHK(u_dev.prog_en, 1'b0)
    $display("leave done");
  endtask

  initial begin
    rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_op = JFP_OP_CMD;
    cmd_word = 15'h0000;
    cmd_skip = 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    t_enter();
    t_refuse();
    t_sig_cal();
    t_fuse();
    t_erase();
    t_load();
    t_read();
    t_leave();
    print_verdict();
  end
endmodule
